// ===== core/pgf_fault_cell.sv
// one fault trigger: latched or live status with clear
`timescale 1ns/1ns
module pgf_fault_cell
    import pgf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic trig,
    input wire logic latch_off,
    input wire logic clr,
    output logic status_q
);
    logic status_d;
    assign status_d = latch_off ? trig : (trig | (status_q & ~clr));
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= 1'b0;
        end else begin
            status_q <= status_d;
        end
    end
endmodule : pgf_fault_cell

// ===== core/pgf_fault_timer.sv
// minimum fault period stretcher
`timescale 1ns/1ns
module pgf_fault_timer
    import pgf_pkg::*;
#(
    parameter int MFP_W = PGF_MFP_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic fault_raw,
    input wire logic min_on,
    input wire logic [MFP_W-1:0] min_period,
    output logic fault_q
);
    logic raw_q;
    logic [MFP_W-1:0] cnt_q;
    logic [MFP_W-1:0] cnt_d;
    logic rise;
    logic stretch;
    assign rise = fault_raw & ~raw_q;
    assign cnt_d = (rise && min_period != '0) ? min_period - 1'b1 :
                   (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    assign stretch = min_on & (cnt_q != '0);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            raw_q <= 1'b0;
            cnt_q <= '0;
            fault_q <= 1'b0;
        end else begin
            raw_q <= fault_raw;
            cnt_q <= cnt_d;
            fault_q <= fault_raw | stretch;
        end
    end
endmodule : pgf_fault_timer

// ===== core/pgf_gen.sv
// pwm generator: counter, update sync, debug, fault handling
`timescale 1ns/1ns
module pgf_gen
    import pgf_pkg::*;
#(
    parameter int CNT_W = PGF_CNT_W,
    parameter int MFP_W = PGF_MFP_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cfg_wr,
    input wire logic cfg_up_down,
    input wire logic cfg_sync_update,
    input wire logic cfg_debug_pause_at_zero,
    input wire logic [1:0] cfg_mode_sync,
    input wire logic [1:0] cfg_deadtime_sync,
    input wire logic cfg_fault_latch_off,
    input wire logic cfg_fault_min_period_on,
    input wire logic cfg_extended_fault_select,
    input wire logic gen_enable,
    input wire logic gen_disable,
    input wire logic global_sync_req,
    input wire logic dbg_halt,
    input wire logic param_wr,
    input wire logic [CNT_W-1:0] param_load,
    input wire logic [CNT_W-1:0] param_cmp_a,
    input wire logic [CNT_W-1:0] param_cmp_b,
    input wire logic deadtime_wr,
    input wire logic [CNT_W-1:0] deadtime_rise,
    input wire logic [CNT_W-1:0] deadtime_fall,
    input wire logic [PGF_N_EXT-1:0] fault_pin,
    input wire logic [PGF_N_EXT-1:0] fault_active_high,
    input wire logic [PGF_N_CMP-1:0] comparator_trig,
    input wire logic [PGF_N_EXT-1:0] fault_sel_ext,
    input wire logic [PGF_N_CMP-1:0] fault_sel_cmp,
    input wire logic [MFP_W-1:0] min_fault_period,
    input wire logic fault_clear,
    input wire logic fault_clear_group,
    input wire logic [PGF_N_CMP-1:0] fault_clear_mask,
    output logic [CNT_W-1:0] count_q,
    output logic out_a_q,
    output logic out_b_q,
    output logic gen_running,
    output logic up_down_q,
    output logic [CNT_W-1:0] load_act_q,
    output logic [CNT_W-1:0] cmp_a_act_q,
    output logic [CNT_W-1:0] cmp_b_act_q,
    output logic [CNT_W-1:0] dt_rise_q,
    output logic [CNT_W-1:0] dt_fall_q,
    output logic fault_active,
    output logic [PGF_N_EXT-1:0] fault_status_ext,
    output logic [PGF_N_CMP-1:0] fault_status_cmp
);
    logic en_q;
    logic sync_upd_q;
    logic dbg_pause_q;
    logic latch_off_q;
    logic min_on_q;
    logic ext_sel_q;
    logic dir_up_q;
    logic glob_q;
    pgf_sync_t mode_pol_q;
    pgf_sync_t dt_pol_q;
    logic mode_pend_q;
    logic mode_new_q;
    logic par_pend_q;
    logic [CNT_W-1:0] load_new_q;
    logic [CNT_W-1:0] cmpa_new_q;
    logic [CNT_W-1:0] cmpb_new_q;
    logic dt_pend_q;
    logic [CNT_W-1:0] dt_rise_new_q;
    logic [CNT_W-1:0] dt_fall_new_q;
    logic [CNT_W-1:0] count_d;
    logic dir_up_d;
    logic hold;
    logic run;
    logic zero;
    logic apply_par;
    logic apply_mode;
    logic apply_dt;
    logic [CNT_W-1:0] load_eff;
    logic ud_eff;
    logic en_d;
    logic glob_d;
    logic [PGF_N_EXT-1:0] ext_sensed;
    logic [PGF_N_EXT-1:0] clr_ext;
    logic [PGF_N_CMP-1:0] clr_cmp;
    logic fault_raw;

    assign hold = dbg_halt & dbg_pause_q & (count_q == '0);
    assign run = en_q & ~hold;
    assign gen_running = en_q;
    assign zero = run & (count_q == '0);
    assign apply_par = par_pend_q & zero & (~sync_upd_q | glob_q);
    assign apply_mode = mode_pend_q & zero & ((mode_pol_q == PGF_SYNC_LOCAL) | glob_q);
    assign apply_dt = dt_pend_q & zero & ((dt_pol_q == PGF_SYNC_LOCAL) | glob_q);
    assign load_eff = apply_par ? load_new_q : load_act_q;
    assign ud_eff = apply_mode ? mode_new_q : up_down_q;
    assign en_d = cfg_wr ? 1'b0 : gen_enable ? 1'b1 : gen_disable ? 1'b0 : en_q;
    // global command kept until zero, set wins
    assign glob_d = global_sync_req | (glob_q & ~zero);

    // counter next value
    always_comb begin
        count_d = count_q;
        dir_up_d = dir_up_q;
        if (zero) begin
            if (!ud_eff) begin
                count_d = load_eff;
            end else begin
                dir_up_d = 1'b1;
                count_d = (load_eff != '0) ? CNT_W'(1) : '0;
            end
        end else if (run) begin
            if (up_down_q && dir_up_q) begin
                if (count_q >= load_act_q) begin
                    dir_up_d = 1'b0;
                    count_d = count_q - 1'b1;
                end else begin
                    count_d = count_q + 1'b1;
                end
            end else begin
                count_d = count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
            dir_up_q <= PGF_RST_DIR_UP;
            en_q <= PGF_RST_EN;
            glob_q <= 1'b0;
        end else begin
            count_q <= count_d;
            dir_up_q <= dir_up_d;
            en_q <= en_d;
            glob_q <= glob_d;
        end
    end

    // configuration flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_upd_q <= PGF_RST_SYNC_UPD;
            dbg_pause_q <= PGF_RST_DBG_PAUSE;
            latch_off_q <= PGF_RST_LATCH_OFF;
            min_on_q <= PGF_RST_MIN_PER_ON;
            ext_sel_q <= PGF_RST_EXT_SEL;
            mode_pol_q <= PGF_SYNC_NONE;
            dt_pol_q <= PGF_SYNC_NONE;
        end else if (cfg_wr) begin
            sync_upd_q <= cfg_sync_update;
            dbg_pause_q <= cfg_debug_pause_at_zero;
            latch_off_q <= cfg_fault_latch_off;
            min_on_q <= cfg_fault_min_period_on;
            ext_sel_q <= cfg_extended_fault_select;
            mode_pol_q <= pgf_sync_t'(cfg_mode_sync);
            dt_pol_q <= pgf_sync_t'(cfg_deadtime_sync);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            up_down_q <= PGF_RST_UP_DOWN;
            mode_new_q <= PGF_RST_UP_DOWN;
            mode_pend_q <= 1'b0;
        end else if (cfg_wr && pgf_sync_t'(cfg_mode_sync) == PGF_SYNC_NONE) begin
            up_down_q <= cfg_up_down;
            mode_pend_q <= 1'b0;
        end else if (cfg_wr) begin
            mode_new_q <= cfg_up_down;
            mode_pend_q <= 1'b1;
        end else if (apply_mode) begin
            up_down_q <= mode_new_q;
            mode_pend_q <= 1'b0;
        end
    end

    // period and compares move at zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            par_pend_q <= 1'b0;
            load_new_q <= '0;
            cmpa_new_q <= '0;
            cmpb_new_q <= '0;
            load_act_q <= '0;
            cmp_a_act_q <= '0;
            cmp_b_act_q <= '0;
        end else begin
            if (param_wr) begin
                load_new_q <= param_load;
                cmpa_new_q <= param_cmp_a;
                cmpb_new_q <= param_cmp_b;
            end
            par_pend_q <= param_wr | (par_pend_q & ~apply_par);
            if (apply_par) begin
                load_act_q <= load_new_q;
                cmp_a_act_q <= cmpa_new_q;
                cmp_b_act_q <= cmpb_new_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dt_pend_q <= 1'b0;
            dt_rise_new_q <= '0;
            dt_fall_new_q <= '0;
            dt_rise_q <= '0;
            dt_fall_q <= '0;
        end else if (deadtime_wr && dt_pol_q == PGF_SYNC_NONE) begin
            dt_rise_q <= deadtime_rise;
            dt_fall_q <= deadtime_fall;
            dt_pend_q <= 1'b0;
        end else if (deadtime_wr) begin
            dt_rise_new_q <= deadtime_rise;
            dt_fall_new_q <= deadtime_fall;
            dt_pend_q <= 1'b1;
        end else if (apply_dt) begin
            dt_rise_q <= dt_rise_new_q;
            dt_fall_q <= dt_fall_new_q;
            dt_pend_q <= 1'b0;
        end
    end

    // outputs: left aligned in down mode, centred in up/down
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            out_a_q <= ~fault_active & (up_down_q ? (count_d < cmp_a_act_q) : (count_d >= cmp_a_act_q));
            out_b_q <= ~fault_active & (up_down_q ? (count_d < cmp_b_act_q) : (count_d >= cmp_b_act_q));
        end
    end

    assign ext_sensed = ~(fault_pin ^ fault_active_high);
    assign clr_ext = (fault_clear && fault_clear_group == PGF_GROUP_EXT) ? fault_clear_mask[PGF_N_EXT-1:0] : '0;
    assign clr_cmp = (fault_clear && fault_clear_group == PGF_GROUP_CMP) ? fault_clear_mask : '0;

    genvar gi;
    generate
        for (gi = 0; gi < PGF_N_EXT; gi++) begin : g_ext
            pgf_fault_cell u_cell (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .trig(ext_sensed[gi]),
                .latch_off(latch_off_q),
                .clr(clr_ext[gi]),
                .status_q(fault_status_ext[gi])
            );
        end
        for (gi = 0; gi < PGF_N_CMP; gi++) begin : g_cmp
            pgf_fault_cell u_cell (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .trig(comparator_trig[gi]),
                .latch_off(latch_off_q),
                .clr(clr_cmp[gi]),
                .status_q(fault_status_cmp[gi])
            );
        end
    endgenerate

    assign fault_raw = ext_sel_q ? (|(fault_sel_ext & fault_status_ext) | |(fault_sel_cmp & fault_status_cmp))
                                 : fault_status_ext[0];

    pgf_fault_timer #(
        .MFP_W(MFP_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .fault_raw(fault_raw),
        .min_on(min_on_q),
        .min_period(min_fault_period),
        .fault_q(fault_active)
    );

    // checks
    AST_CFG_DISABLES: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_wr |=> !gen_running)
        else $error("config write left generator enabled");
    AST_DOWN_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        zero && !ud_eff |=> count_q == load_act_q)
        else $error("down counter did not reload at zero");
    AST_DOWN_DEC: assert property (@(posedge clk_sys) disable iff (!rst_b)
        run && !up_down_q && count_q != '0 |=> count_q == $past(count_q) - 1'b1)
        else $error("down counter did not decrement");
    AST_UD_TURN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        run && up_down_q && dir_up_q && count_q != '0 && count_q >= load_act_q |=> !dir_up_q)
        else $error("up/down counter did not turn at load");
    AST_SYNC_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        par_pend_q && sync_upd_q && !glob_q |=> $stable(load_act_q))
        else $error("sync update applied without sync event");
    AST_APPLY_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(load_act_q) |-> $past(zero))
        else $error("period changed away from zero");
    AST_NOSYNC_APPLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        zero && par_pend_q && !sync_upd_q |=> load_act_q == $past(load_new_q))
        else $error("non-sync update not applied at zero");
    AST_DBG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dbg_halt && dbg_pause_q && count_q == '0 |=> count_q == '0)
        else $error("counter not held at zero in debug pause");
    AST_DBG_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        en_q && dbg_halt && !dbg_pause_q && count_q != '0 |=> count_q != $past(count_q))
        else $error("counter stopped in debug run");
    AST_DISABLED_STILL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !en_q |=> $stable(count_q))
        else $error("disabled counter moved");
    AST_LEGACY_SRC: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ext_sel_q && fault_status_ext[0] |=> fault_active)
        else $error("first fault input not signalled");
    AST_MIN_PERIOD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        min_on_q && $rose(fault_active) && min_fault_period >= MFP_W'(3) |-> fault_active[*3])
        else $error("fault shorter than minimum period");
    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !latch_off_q && clr_ext[0] && !ext_sensed[0] |=> !fault_status_ext[0])
        else $error("latched trigger not cleared");
    COV_UD_TURN: cover property (@(posedge clk_sys) disable iff (!rst_b)
        up_down_q && dir_up_q ##1 !dir_up_q);
    COV_GLOBAL_APPLY: cover property (@(posedge clk_sys) disable iff (!rst_b)
        apply_par && sync_upd_q);
    COV_STRETCH: cover property (@(posedge clk_sys) disable iff (!rst_b)
        fault_active && !fault_raw && min_on_q);
    COV_LATCH_CLEAR: cover property (@(posedge clk_sys) disable iff (!rst_b)
        fault_status_cmp[0] && clr_cmp[0] ##1 !fault_status_cmp[0]);
endmodule : pgf_gen

// ===== inc/pgf_pkg.sv
// shared constants and types of the pwm generator
package pgf_pkg;
    localparam int PGF_N_EXT = 4;
    localparam int PGF_N_CMP = 8;
    localparam int PGF_CNT_W = 16;
    localparam int PGF_MFP_W = 16;
    localparam logic PGF_GROUP_EXT = 1'b0;
    localparam logic PGF_GROUP_CMP = 1'b1;
    localparam logic PGF_RST_EN = 1'b0;
    localparam logic PGF_RST_UP_DOWN = 1'b0;
    localparam logic PGF_RST_SYNC_UPD = 1'b0;
    localparam logic PGF_RST_DBG_PAUSE = 1'b0;
    localparam logic PGF_RST_LATCH_OFF = 1'b1;
    localparam logic PGF_RST_MIN_PER_ON = 1'b0;
    localparam logic PGF_RST_EXT_SEL = 1'b0;
    localparam logic PGF_RST_DIR_UP = 1'b1;
    typedef enum logic [1:0] {
        PGF_SYNC_NONE = 2'b00,
        PGF_SYNC_LOCAL = 2'b01,
        PGF_SYNC_GLOBAL = 2'b10
    } pgf_sync_t;
endpackage : pgf_pkg

// ===== tb/pgf_fault_src.sv
// model of the external fault pins and comparator triggers
`timescale 1ns/1ns
module pgf_fault_src
    import pgf_pkg::*;
(
    input wire logic [PGF_N_EXT-1:0] req_ext,
    input wire logic [PGF_N_EXT-1:0] fault_active_high,
    input wire logic [PGF_N_CMP-1:0] req_cmp,
    output logic [PGF_N_EXT-1:0] fault_pin,
    output logic [PGF_N_CMP-1:0] comparator_trig
);
    assign fault_pin = req_ext ~^ fault_active_high;
    assign comparator_trig = req_cmp;
endmodule : pgf_fault_src

// ===== tb/testbench.sv
// self-checking bench of the pwm generator
`timescale 1ns/1ns
module testbench
    import pgf_pkg::*;
;
    logic clk_sys = 0, rst_b = 0, cfg_wr = 0, cfg_up_down = 0, cfg_sync_update = 0, cfg_debug_pause_at_zero = 0;
    logic cfg_fault_latch_off = 1, cfg_fault_min_period_on = 0, cfg_extended_fault_select = 0, gen_enable = 0;
    logic gen_disable = 0, global_sync_req = 0, dbg_halt = 0, param_wr = 0, deadtime_wr = 0, fault_clear = 0;
    logic fault_clear_group = 0, out_a_q, out_b_q, gen_running, up_down_q, fault_active;
    logic [1:0] cfg_mode_sync = 0, cfg_deadtime_sync = 0;
    logic [PGF_CNT_W-1:0] param_load = 0, param_cmp_a = 0, param_cmp_b = 0, deadtime_rise = 0, deadtime_fall = 0;
    logic [PGF_CNT_W-1:0] count_q, load_act_q, cmp_a_act_q, cmp_b_act_q, dt_rise_q, dt_fall_q, ld, c;
    logic [PGF_MFP_W-1:0] min_fault_period = 0;
    logic [3:0] fault_pin, fault_active_high = 4'hF, fault_sel_ext = 0, req_ext = 0, fault_status_ext;
    logic [7:0] comparator_trig, fault_sel_cmp = 0, fault_clear_mask = 0, req_cmp = 0, fault_status_cmp;
    int miscompares = 0, tests_run = 0, seed = 46, i, n;

    always #5 clk_sys = ~clk_sys;

    pgf_fault_src src_u (.req_ext, .fault_active_high, .req_cmp, .fault_pin, .comparator_trig);

    pgf_gen #(.CNT_W(PGF_CNT_W), .MFP_W(PGF_MFP_W)) dut_u (
        .clk_sys, .rst_b, .cfg_wr, .cfg_up_down, .cfg_sync_update, .cfg_debug_pause_at_zero,
        .cfg_mode_sync, .cfg_deadtime_sync, .cfg_fault_latch_off, .cfg_fault_min_period_on,
        .cfg_extended_fault_select, .gen_enable, .gen_disable, .global_sync_req, .dbg_halt,
        .param_wr, .param_load, .param_cmp_a, .param_cmp_b, .deadtime_wr, .deadtime_rise,
        .deadtime_fall, .fault_pin, .fault_active_high, .comparator_trig, .fault_sel_ext,
        .fault_sel_cmp, .min_fault_period, .fault_clear, .fault_clear_group, .fault_clear_mask,
        .count_q, .out_a_q, .out_b_q, .gen_running, .up_down_q, .load_act_q, .cmp_a_act_q,
        .cmp_b_act_q, .dt_rise_q, .dt_fall_q, .fault_active, .fault_status_ext, .fault_status_cmp
    );

    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic step(input int cyc);
        repeat (cyc) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask : pulse

    task automatic wait_cnt(input logic [15:0] v, input int lim);
        for (i = 0; i < lim && count_q !== v; i++) step(1);
        if (count_q !== v) begin
            miscompares++;
            $display("mismatch at %0t: wait limit", $time);
            conclude();
        end
    endtask : wait_cnt

    task automatic cfg(input logic ud, sy, pz, lo, mn, ex, input logic [1:0] ms);
        {cfg_up_down, cfg_sync_update, cfg_debug_pause_at_zero} = {ud, sy, pz};
        {cfg_fault_latch_off, cfg_fault_min_period_on, cfg_extended_fault_select, cfg_mode_sync} = {lo, mn, ex, ms};
        pulse(cfg_wr);
        chk(gen_running, 0, "cfg leaves disabled");
    endtask : cfg

    initial begin
        ld = 16'(3 + $unsigned($random(seed)) % 8);
        step(10);
        chk(count_q, 0, "reset count");
        chk({gen_running, up_down_q, fault_active}, 0, "reset flags");
        rst_b = 1;
        step(1);
        $display("test reset done");
        // down counting, parameters at zero, immediate deadtime
        cfg(0, 0, 0, 1, 0, 0, PGF_SYNC_NONE);
        {param_load, param_cmp_a, param_cmp_b, deadtime_rise} = {ld, ld >> 1, 16'h0001, ld};
        pulse(param_wr);
        pulse(deadtime_wr);
        chk(dt_rise_q, ld, "deadtime immediate");
        pulse(gen_enable);
        wait_cnt(ld, 10);
        chk(load_act_q, ld, "load at zero");
        chk(cmp_a_act_q, ld >> 1, "compare a at zero");
        for (n = 0; n <= ld; n++) begin
            chk(count_q, 16'(ld - n), "down count");
            chk(out_a_q, 16'((ld - n) >= (ld >> 1)), "down out a");
            chk(out_b_q, 16'((ld - n) >= 1), "down out b");
            step(1);
        end
        chk(count_q, ld, "down reload");
        $display("test down done");
        // up/down counting, mode change at local zero
        cfg_deadtime_sync = PGF_SYNC_LOCAL;
        cfg(1, 0, 0, 1, 0, 0, PGF_SYNC_LOCAL);
        deadtime_rise = ld + 16'h0001;
        pulse(deadtime_wr);
        chk(dt_rise_q, ld, "deadtime waits zero");
        chk(up_down_q, 0, "mode waits zero");
        pulse(gen_enable);
        wait_cnt(0, 2 * ld + 4);
        step(1);
        chk(up_down_q, 1, "mode at zero");
        chk(dt_rise_q, ld + 16'h0001, "deadtime at zero");
        wait_cnt(0, 2 * ld + 4);
        for (n = 0; n <= 2 * ld; n++) begin
            chk(count_q, 16'(n <= ld ? n : 2 * ld - n), "up down count");
            chk(out_a_q, 16'((n <= ld ? n : 2 * ld - n) < (ld >> 1)), "centred out a");
            step(1);
        end
        $display("test updown done");
        // synchronous update waits for global sync
        cfg(0, 1, 0, 1, 0, 0, PGF_SYNC_NONE);
        param_load = ld + 16'h0002;
        pulse(param_wr);
        pulse(gen_enable);
        step(3 * ld + 6);
        chk(load_act_q, ld, "held pending");
        pulse(global_sync_req);
        wait_cnt(ld + 16'h0002, ld + 6);
        chk(load_act_q, ld + 16'h0002, "applied on sync");
        $display("test sync done");
        // debug pause and debug run
        for (n = 1; n >= 0; n--) begin
            cfg(0, 0, n[0], 1, 0, 0, PGF_SYNC_NONE);
            pulse(gen_enable);
            dbg_halt = 1;
            wait_cnt(0, 3 * ld + 9);
            step(n == 1 ? 20 : 1);
            chk(count_q, n == 1 ? 16'h0000 : ld + 16'h0002, "debug halt");
            dbg_halt = 0;
            step(1);
            if (n == 1) chk(count_q, ld + 16'h0002, "debug resume");
        end
        $display("test debug done");
        // disable freezes, enable restarts
        pulse(gen_disable);
        c = count_q;
        step(5);
        chk(count_q, c, "disabled frozen");
        pulse(gen_enable);
        step(1);
        chk(count_q !== c, 1, "enabled counts");
        $display("test gate done");
        // legacy source and sense polarity
        cfg(0, 0, 0, 1, 0, 0, PGF_SYNC_NONE);
        for (n = 0; n < 2; n++) begin
            fault_active_high = {4{n[0]}};
            req_ext = 4'b0010;
            req_cmp = 8'hFF;
            step(4);
            chk(fault_active, 0, "legacy ignores others");
            chk(fault_status_ext, 4'b0010, "live status");
            req_ext = 4'b0001;
            step(2);
            chk(fault_active, 1, "first input fault");
            {req_ext, req_cmp} = 0;
            step(3);
            chk(fault_active, 0, "live fault ends");
        end
        $display("test legacy done");
        // latched comparator trigger and group clear
        cfg(0, 0, 0, 0, 0, 1, PGF_SYNC_NONE);
        {fault_sel_cmp, req_cmp} = {8'h04, 8'h04};
        step(1);
        req_cmp = 0;
        step(3);
        chk(fault_status_cmp, 8'h04, "latched status");
        chk(fault_active, 1, "extended source");
        {fault_clear_group, fault_clear_mask} = {PGF_GROUP_EXT, 8'h05};
        pulse(fault_clear);
        step(1);
        chk(fault_status_cmp, 8'h04, "other group clear");
        fault_clear_group = PGF_GROUP_CMP;
        pulse(fault_clear);
        step(1);
        chk(fault_status_cmp, 0, "group clear");
        step(2);
        chk(fault_active, 0, "cleared fault");
        $display("test latch done");
        // minimum fault period stretch
        fault_active_high = 4'hF;
        min_fault_period = 16'(5 + $unsigned($random(seed)) % 16);
        cfg(0, 0, 0, 1, 1, 0, PGF_SYNC_NONE);
        req_ext = 1;
        step(1);
        req_ext = 0;
        for (i = 0; i < 6 && fault_active !== 1; i++) step(1);
        for (n = 0; n < 200 && fault_active === 1; n++) step(1);
        chk(n >= min_fault_period && n <= min_fault_period + 2, 1, "min period");
        $display("test minper done");
        conclude();
    end
endmodule : testbench
